//--- src/usr_status.sv
// Line and modem condition reporting, scratch storage and host bus front end of the UART.
`timescale 1ns/1ps
`include "usr_regs.svh"

// Contract
// - Received word sets ready flag; buffer read clears.
// - Unread word replaced sets overrun; line read clears.
// - Bad parity sets parity flag; line read clears.
// - Bad stop bit sets framing flag; read clears.
// - Long low input sets break flag; read clears.
// - Holding empty flag; ident read or write clears.
// - Idle flag only when holding and shifter empty.
// - Line condition bit 7 reads zero always.
// - Send permit change sets bit 0, interrupts.
// - Modem set change sets bit 1, interrupts.
// - Incoming call trailing edge sets bit 2.
// - Carrier change sets bit 3, interrupts.
// - Bits 4 to 7 show inverted input levels outside loopback.
// - Scratch register reads back, affects nothing else.
// - Separate buses; output never tri-stated or gated.
// - Address captured on clock while strobe enabled.
// - Single system clock, no oscillator interface.
// - Loopback feeds modem outputs into status logic.
module usr_status (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Host register bus
  input wire logic addr_strobe_n,
  input wire usr_pkg::usr_addr_t addr,
  input wire logic chip_sel,
  input wire logic rd,
  input wire logic wr,
  input wire usr_pkg::usr_byte_t din,
  output usr_pkg::usr_byte_t dout,
  // Neighbouring register context
  input wire logic dlab_active,
  input wire usr_pkg::usr_byte_t iid_rdata,
  input wire usr_pkg::usr_byte_t ext_rdata,
  // Receiver events
  input wire logic rx_valid,
  input wire usr_pkg::usr_byte_t rx_word,
  input wire logic rx_parity_err,
  input wire logic rx_frame_err,
  input wire logic rx_break,
  // Transmitter side
  output logic tx_valid,
  output usr_pkg::usr_byte_t tx_data,
  input wire logic tx_ready,
  input wire logic tx_shift_busy,
  output logic thr_ready,
  // Modem inputs and loopback sources
  input wire logic send_permit_n,
  input wire logic modem_set_n,
  input wire logic incoming_call_level_n,
  input wire logic carrier_n,
  input wire logic loop_enable,
  input wire logic loop_dtr,
  input wire logic loop_rts,
  input wire logic loop_out1,
  input wire logic loop_out2,
  // Interrupt requests to the priority logic
  output logic irq_rx_data,
  output logic irq_line,
  output logic irq_thr_empty,
  output logic irq_modem
);
  import usr_pkg::*;

  usr_state_t st;
  usr_state_t next_st;

  logic rd_pulse;
  logic wr_pulse;
  logic rxtx_sel;
  logic rbr_rd;
  logic thr_wr;
  logic iid_rd;
  logic line_rd;
  logic modem_rd;
  logic scr_wr;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_empty;
  logic [3:0] lvl_now;
  logic [3:0] delta_set;
  usr_byte_t line_val;
  usr_byte_t modem_val;

  // Strobes act on their first cycle only, so a long read clears a flag once.
  assign rd_pulse = chip_sel & rd & ~st.rd_q;
  assign wr_pulse = chip_sel & wr & ~st.wr_q;
  assign rxtx_sel = (st.addr_q == `USR_OFS_RXTX) & ~dlab_active;
  assign rbr_rd = rd_pulse & rxtx_sel;
  assign thr_wr = wr_pulse & rxtx_sel & fifo_ready;
  assign iid_rd = rd_pulse & (st.addr_q == `USR_OFS_IDENT);
  assign line_rd = rd_pulse & (st.addr_q == `USR_OFS_LINE);
  assign modem_rd = rd_pulse & (st.addr_q == `USR_OFS_MODEM);
  assign scr_wr = wr_pulse & (st.addr_q == `USR_OFS_SCRATCH);
  assign fifo_empty = ~fifo_valid;

  // In loopback the external modem pins are ignored entirely.
  always_comb begin
    if (loop_enable) begin
      lvl_now[`USR_LV_SEND] = loop_rts;
      lvl_now[`USR_LV_SET] = loop_dtr;
      lvl_now[`USR_LV_CALL] = loop_out1;
      lvl_now[`USR_LV_CARR] = loop_out2;
    end else begin
      lvl_now[`USR_LV_SEND] = ~send_permit_n;
      lvl_now[`USR_LV_SET] = ~modem_set_n;
      lvl_now[`USR_LV_CALL] = ~incoming_call_level_n;
      lvl_now[`USR_LV_CARR] = ~carrier_n;
    end
  end

  always_comb begin
    delta_set[`USR_MC_DSEND] = lvl_now[`USR_LV_SEND] ^ st.lvl[`USR_LV_SEND];
    delta_set[`USR_MC_DSET] = lvl_now[`USR_LV_SET] ^ st.lvl[`USR_LV_SET];
    delta_set[`USR_MC_TCALL] = st.lvl[`USR_LV_CALL] & ~lvl_now[`USR_LV_CALL];
    delta_set[`USR_MC_DCARR] = lvl_now[`USR_LV_CARR] ^ st.lvl[`USR_LV_CARR];
  end

  always_comb begin
    line_val = '0;
    line_val[`USR_LC_RDR] = st.rdr;
    line_val[`USR_LC_OVR] = st.ovr;
    line_val[`USR_LC_PAR] = st.par;
    line_val[`USR_LC_FRM] = st.frm;
    line_val[`USR_LC_BRK] = st.brk;
    line_val[`USR_LC_THE] = st.thre;
    line_val[`USR_LC_TMT] = st.temt;
    line_val[`USR_LC_RSV] = 1'b0;
    modem_val = {st.lvl, st.delta};
  end

  always_comb begin
    next_st = st;
    next_st.rd_q = chip_sel & rd;
    next_st.wr_q = chip_sel & wr;
    if (!addr_strobe_n) begin
      next_st.addr_q = addr;
    end
    // Receive buffer and ready flag; a new word wins over a read in the same cycle.
    if (rbr_rd) begin
      next_st.rdr = 1'b0;
    end
    if (rx_valid) begin
      next_st.rbuf = rx_word;
      next_st.rdr = 1'b1;
    end
    // Error flags clear on a line read unless a fresh event lands at once.
    if (line_rd) begin
      next_st.ovr = 1'b0;
      next_st.par = 1'b0;
      next_st.frm = 1'b0;
      next_st.brk = 1'b0;
    end
    if (rx_valid && st.rdr && !rbr_rd) begin
      next_st.ovr = 1'b1;
    end
    if (rx_valid && rx_parity_err) begin
      next_st.par = 1'b1;
    end
    if (rx_valid && rx_frame_err) begin
      next_st.frm = 1'b1;
    end
    if (rx_break) begin
      next_st.brk = 1'b1;
    end
    // Holding empty is raised when the buffer drains, so a clear by ident read sticks.
    next_st.empty_q = fifo_empty;
    if (iid_rd || thr_wr) begin
      next_st.thre = 1'b0;
    end
    // A write in the same cycle refills the buffer, so the flag must stay low.
    if (fifo_empty && !st.empty_q && !thr_wr) begin
      next_st.thre = 1'b1;
    end
    next_st.temt = fifo_empty & ~tx_shift_busy & ~thr_wr;
    // Modem changes clear on read; a change in the read cycle survives.
    next_st.lvl = lvl_now;
    if (modem_rd) begin
      next_st.delta = 4'h0;
    end
    next_st.delta = next_st.delta | delta_set;
    if (scr_wr) begin
      next_st.scratch = din;
    end
    // Output data is a registered copy of the read mux, independent of the strobes.
    case (st.addr_q)
      `USR_OFS_RXTX: next_st.dout = dlab_active ? ext_rdata : st.rbuf;
      `USR_OFS_IDENT: next_st.dout = iid_rdata;
      `USR_OFS_LINE: next_st.dout = line_val;
      `USR_OFS_MODEM: next_st.dout = modem_val;
      `USR_OFS_SCRATCH: next_st.dout = st.scratch;
      default: next_st.dout = ext_rdata;
    endcase
    next_st.irq_rda = next_st.rdr;
    next_st.irq_rls = next_st.ovr | next_st.par | next_st.frm | next_st.brk;
    next_st.irq_thre = next_st.thre;
    next_st.irq_ms = |next_st.delta;
  end

  // Everything, bus front end included, runs from the one system clock.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.thre <= 1'b1;
      st.temt <= 1'b1;
      st.empty_q <= 1'b1;
      st.lvl <= `USR_RST_LVL;
      st.rbuf <= `USR_RST_BYTE;
      st.scratch <= `USR_RST_BYTE;
      st.dout <= `USR_RST_BYTE;
      st.irq_thre <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Writes to a full holding buffer are dropped; thr_ready lets the host avoid that.
  usr_fifo #(
    .WIDTH(8),
    .DEPTH(4)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(thr_wr),
    .in_data(din),
    .in_ready(fifo_ready),
    .out_valid(fifo_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  assign dout = st.dout;
  assign tx_valid = fifo_valid;
  assign thr_ready = fifo_ready;
  assign irq_rx_data = st.irq_rda;
  assign irq_line = st.irq_rls;
  assign irq_thr_empty = st.irq_thre;
  assign irq_modem = st.irq_ms;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_ready_sets: assert property (rx_valid |=> st.rdr && st.rbuf == $past(rx_word) && irq_rx_data)
    else $error("ready flag not set by received word");

  chk_ready_clears: assert property (rbr_rd && !rx_valid |=> !st.rdr && !irq_rx_data)
    else $error("ready flag not cleared by buffer read");

  chk_overrun_sets: assert property (rx_valid && st.rdr && !rbr_rd |=> st.ovr && irq_line)
    else $error("overrun not flagged");

  chk_parity_sets: assert property (rx_valid && rx_parity_err |=> st.par && irq_line)
    else $error("parity fault not flagged");

  chk_framing_clear: assert property (line_rd && !rx_valid |=> !st.frm && !st.par)
    else $error("fault flags survived a line read");

  chk_break_flag: assert property (rx_break |=> st.brk ##1 (st.brk || $past(line_rd)))
    else $error("break flag wrong");

  chk_holding_clear: assert property (thr_wr |=> !st.thre && !st.temt)
    else $error("holding empty not cleared by write");

  chk_idle_cause: assert property (st.temt |-> $past(fifo_empty && !tx_shift_busy))
    else $error("idle flag without empty transmitter");

  chk_bit7_zero: assert property ($past(st.addr_q) == `USR_OFS_LINE |-> !dout[7])
    else $error("line condition bit 7 not zero");

  chk_send_delta: assert property (lvl_now[0] != st.lvl[0] |=> st.delta[0] && irq_modem)
    else $error("send permit change missed");

  chk_set_delta: assert property (lvl_now[1] != st.lvl[1] |=> st.delta[1])
    else $error("modem set change missed");

  chk_call_edge: assert property (st.delta[2] && !$past(st.delta[2]) |-> $fell(st.lvl[2]))
    else $error("incoming call flag without trailing edge");

  chk_carr_delta: assert property (lvl_now[3] != st.lvl[3] |=> st.delta[3])
    else $error("carrier change missed");

  chk_level_copy: assert property (1'b1 |=> st.lvl == $past(lvl_now))
    else $error("modem levels not tracked");

  chk_scratch_back: assert property (scr_wr ##1 st.addr_q == `USR_OFS_SCRATCH |=> dout == $past(din, 2))
    else $error("scratch did not read back");

  chk_addr_hold: assert property (addr_strobe_n |=> $stable(st.addr_q))
    else $error("address moved without strobe");

  chk_loop_ignore: assert property (loop_enable |-> lvl_now == {loop_out2, loop_out1, loop_dtr, loop_rts})
    else $error("loopback not in effect");

  chk_modem_clear: assert property (modem_rd && delta_set == 4'h0 |=> st.delta == 4'h0)
    else $error("modem changes not cleared");

  chk_reset_vals: assert property (@(posedge sys_clk) $past(srst) |-> st.thre && st.temt && !st.rdr && !st.ovr)
    else $error("wrong flag values after reset");

  chk_ready_hold: assert property (!rx_valid && !rbr_rd |=> $stable(st.rdr))
    else $error("ready flag moved without cause");

  chk_rx_irq: assert property (irq_rx_data == st.rdr)
    else $error("receive interrupt differs from ready flag");

  chk_overrun_clear: assert property (line_rd && !rx_valid && !rx_break |=> !st.ovr && !st.brk)
    else $error("overrun or break survived a line read");

  chk_line_irq: assert property (irq_line == (st.ovr || st.par || st.frm || st.brk))
    else $error("line interrupt differs from error flags");

  chk_frame_sets: assert property (rx_valid && rx_frame_err |=> st.frm && irq_line)
    else $error("framing fault not flagged");

  chk_break_irq: assert property (rx_break |=> irq_line)
    else $error("break did not request line interrupt");

  chk_holding_ident: assert property (iid_rd && !(fifo_empty && !st.empty_q) |=> !st.thre && !irq_thr_empty)
    else $error("holding empty not cleared by ident read");

  chk_holding_drain: assert property (fifo_empty && !st.empty_q && !thr_wr |=> st.thre && irq_thr_empty)
    else $error("holding empty not raised on drain");

  chk_thre_irq: assert property (irq_thr_empty == st.thre)
    else $error("holding interrupt differs from flag");

  chk_idle_busy: assert property (tx_shift_busy |=> !st.temt)
    else $error("idle flag high while shifter busy");

  chk_modem_irq: assert property (irq_modem == (st.delta != 4'h0))
    else $error("modem interrupt differs from change bits");

  chk_modem_mux: assert property (st.addr_q == `USR_OFS_MODEM |=> dout == $past({st.lvl, st.delta}))
    else $error("modem condition not on output bus");

  chk_scratch_mux: assert property (st.addr_q == `USR_OFS_SCRATCH |=> dout == $past(st.scratch))
    else $error("scratch not on output bus");

  chk_scratch_only: assert property (!scr_wr |=> $stable(st.scratch))
    else $error("scratch changed without a write");

  chk_addr_load: assert property (!addr_strobe_n |=> st.addr_q == $past(addr))
    else $error("address not captured under strobe");
endmodule

//--- src/usr_regs.svh
// Register offsets, field positions and reset values of the UART status block.
`ifndef USR_REGS_SVH
`define USR_REGS_SVH

// Register offsets on the captured three-bit address.
`define USR_OFS_RXTX 3'h0
`define USR_OFS_IDENT 3'h2
`define USR_OFS_LINE 3'h5
`define USR_OFS_MODEM 3'h6
`define USR_OFS_SCRATCH 3'h7

// Line condition fields.
`define USR_LC_RDR 0
`define USR_LC_OVR 1
`define USR_LC_PAR 2
`define USR_LC_FRM 3
`define USR_LC_BRK 4
`define USR_LC_THE 5
`define USR_LC_TMT 6
`define USR_LC_RSV 7

// Modem condition fields; the levels sit in bits 4 to 7 in the same order.
`define USR_MC_DSEND 0
`define USR_MC_DSET 1
`define USR_MC_TCALL 2
`define USR_MC_DCARR 3
`define USR_MC_LVL 4

// Modem level index: send permit, modem set, incoming call, carrier.
`define USR_LV_SEND 0
`define USR_LV_SET 1
`define USR_LV_CALL 2
`define USR_LV_CARR 3

// Reset values.
`define USR_RST_LINE 8'h60
`define USR_RST_BYTE 8'h00
`define USR_RST_LVL 4'h0

`endif

//--- src/usr_pkg.sv
// Types shared by the UART status block.
package usr_pkg;

  typedef logic [2:0] usr_addr_t;
  typedef logic [7:0] usr_byte_t;

  typedef struct packed {
    usr_addr_t addr_q;
    logic rd_q;
    logic wr_q;
    usr_byte_t rbuf;
    logic rdr;
    logic ovr;
    logic par;
    logic frm;
    logic brk;
    logic thre;
    logic temt;
    logic empty_q;
    logic [3:0] delta;
    logic [3:0] lvl;
    usr_byte_t scratch;
    usr_byte_t dout;
    logic irq_rda;
    logic irq_rls;
    logic irq_thre;
    logic irq_ms;
  } usr_state_t;

endpackage

//--- src/usr_fifo.sv
// Small shift FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module usr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic valid;
    logic ready;
  } usr_fifo_t;

  usr_fifo_t st;
  usr_fifo_t next_st;

  // Head always sits in slot zero, so the drain side reads a flop directly.
  always_comb begin
    logic push;
    logic pop;
    logic [CW-1:0] wpos;
    push = in_valid & st.ready;
    pop = st.valid & out_ready;
    next_st = st;
    wpos = st.cnt - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_st.mem[i] = st.mem[i+1];
      end
    end
    if (push) begin
      next_st.mem[wpos[CW-2:0]] = in_data;
    end
    next_st.cnt = wpos + CW'(push);
    next_st.valid = (next_st.cnt != '0);
    next_st.ready = (next_st.cnt != FULL);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = st.ready;
  assign out_valid = st.valid;
  assign out_data = st.mem[0];

  chk_fifo_never_over: assert property (@(posedge sys_clk) disable iff (srst) st.cnt <= FULL)
    else $error("fifo count above depth");
endmodule

//--- verif/usr_tx_model.sv
// Transmitter stand-in that drains the holding FIFO and keeps its shifter busy per word.
`timescale 1ns/1ps
module usr_tx_model #(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Holding FIFO head
  input wire logic tx_valid,
  input wire usr_pkg::usr_byte_t tx_data,
  output logic tx_ready,
  output logic tx_shift_busy,
  // Bench control and log
  input wire logic stall,
  output logic [31:0] log_words,
  output int n_taken
);
  import usr_pkg::*;
  int busy_left;
  // A word is taken only while the shifter is free, so the idle flag can be seen low with an empty FIFO.
  assign tx_ready = !stall && (busy_left == 0);
  assign tx_shift_busy = (busy_left != 0);
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_left <= 0;
      log_words <= 32'h0000_0000;
      n_taken <= 0;
    end else if (tx_valid && tx_ready) begin
      busy_left <= BUSY_CYC;
      log_words <= {log_words[23:0], tx_data};
      n_taken <= n_taken + 1;
    end else if (busy_left != 0) begin
      busy_left <= busy_left - 1;
    end
  end
endmodule

//--- verif/usr_status_tb.sv
// Self-checking bench for the UART status block.
`timescale 1ns/1ps
`include "usr_regs.svh"
module usr_status_tb;
  import usr_pkg::*;
  logic sys_clk, srst = 1'b1, addr_strobe_n = 1'b1, chip_sel = 1'b0, rd = 1'b0, wr = 1'b0, stall = 1'b0;
  logic dlab_active = 1'b0, rx_valid = 1'b0, rx_parity_err = 1'b0, rx_frame_err = 1'b0, rx_break = 1'b0;
  logic loop_enable = 1'b0, loop_dtr = 1'b0, loop_rts = 1'b0, loop_out1 = 1'b0, loop_out2 = 1'b0;
  logic tx_valid, tx_ready, tx_shift_busy, thr_ready, irq_rx_data, irq_line, irq_thr_empty, irq_modem;
  logic [3:0] mdm_n = 4'hF;
  usr_addr_t addr = 3'h0;
  usr_byte_t din = 8'h00, iid_rdata = 8'hC1, ext_rdata = 8'h5E, rx_word = 8'h00;
  usr_byte_t dout, tx_data, exp_val;
  logic [31:0] log_words;
  int n_taken, error_cnt, n_checks, k;

  usr_status DUT (.sys_clk(sys_clk), .srst(srst), .addr_strobe_n(addr_strobe_n), .addr(addr),
    .chip_sel(chip_sel), .rd(rd), .wr(wr), .din(din), .dout(dout), .dlab_active(dlab_active),
    .iid_rdata(iid_rdata), .ext_rdata(ext_rdata), .rx_valid(rx_valid), .rx_word(rx_word),
    .rx_parity_err(rx_parity_err), .rx_frame_err(rx_frame_err), .rx_break(rx_break), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_shift_busy(tx_shift_busy), .thr_ready(thr_ready),
    .send_permit_n(mdm_n[0]), .modem_set_n(mdm_n[1]), .incoming_call_level_n(mdm_n[2]),
    .carrier_n(mdm_n[3]), .loop_enable(loop_enable), .loop_dtr(loop_dtr), .loop_rts(loop_rts),
    .loop_out1(loop_out1), .loop_out2(loop_out2), .irq_rx_data(irq_rx_data), .irq_line(irq_line),
    .irq_thr_empty(irq_thr_empty), .irq_modem(irq_modem));

  usr_tx_model #(.BUSY_CYC(20)) u_tx (.sys_clk(sys_clk), .srst(srst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_shift_busy(tx_shift_busy), .stall(stall),
    .log_words(log_words), .n_taken(n_taken));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk_byte(input usr_byte_t got, input usr_byte_t exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The address is moved away once the strobe is released, so only a captured address can answer.
  task automatic rd_reg(input usr_addr_t a, output usr_byte_t d);
    @(posedge sys_clk) addr_strobe_n <= 1'b0;
    addr <= a;
    @(posedge sys_clk) addr_strobe_n <= 1'b1;
    addr <= ~a;
    @(posedge sys_clk) chip_sel <= 1'b1;
    rd <= 1'b1;
    @(posedge sys_clk) chip_sel <= 1'b0;
    rd <= 1'b0;
    #1 d = dout;
  endtask

  task automatic wr_reg(input usr_addr_t a, input usr_byte_t d);
    @(posedge sys_clk) addr_strobe_n <= 1'b0;
    addr <= a;
    @(posedge sys_clk) addr_strobe_n <= 1'b1;
    addr <= ~a;
    chip_sel <= 1'b1;
    wr <= 1'b1;
    din <= d;
    @(posedge sys_clk) chip_sel <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rx_pulse(input usr_byte_t w, input logic p, input logic f, input logic b);
    @(posedge sys_clk) rx_valid <= ~b;
    rx_word <= w;
    rx_parity_err <= p;
    rx_frame_err <= f;
    rx_break <= b;
    @(posedge sys_clk) rx_valid <= 1'b0;
    rx_break <= 1'b0;
    rx_parity_err <= 1'b0;
    rx_frame_err <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input usr_addr_t a, input usr_byte_t exp, input string what);
    usr_byte_t v;
    rd_reg(a, v);
    chk_byte(v, exp, what);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    rd_chk(`USR_OFS_LINE, 8'h60, "line after reset");
    rd_chk(`USR_OFS_MODEM, 8'h00, "modem after reset");
    chk_bit(irq_thr_empty, 1'b1, "holding irq after reset");
    $display("test reset done");
    wr_reg(`USR_OFS_SCRATCH, 8'hA5);
    rd_chk(`USR_OFS_SCRATCH, 8'hA5, "scratch readback");
    rd_chk(`USR_OFS_LINE, 8'h60, "line untouched by scratch");
    rd_chk(3'h3, 8'h5E, "neighbour value on output bus");
    $display("test scratch done");
    rx_pulse(8'h3C, 1'b1, 1'b0, 1'b0);
    chk_bit(irq_rx_data, 1'b1, "rx irq");
    chk_bit(irq_line, 1'b1, "line irq");
    rd_chk(`USR_OFS_LINE, 8'h65, "parity word");
    rd_chk(`USR_OFS_LINE, 8'h61, "parity cleared");
    rd_chk(`USR_OFS_RXTX, 8'h3C, "rx buffer");
    rd_chk(`USR_OFS_LINE, 8'h60, "ready cleared");
    chk_bit(irq_rx_data, 1'b0, "rx irq cleared");
    rx_pulse(8'h5A, 1'b0, 1'b1, 1'b0);
    rx_pulse(8'hC3, 1'b0, 1'b0, 1'b0);
    rx_pulse(8'h00, 1'b0, 1'b0, 1'b1);
    rd_chk(`USR_OFS_LINE, 8'h7B, "overrun framing break");
    chk_bit(irq_line, 1'b0, "line irq cleared");
    rd_chk(`USR_OFS_LINE, 8'h61, "errors cleared");
    rd_chk(`USR_OFS_RXTX, 8'hC3, "newest word kept");
    $display("test receive done");
    @(posedge sys_clk) stall <= 1'b1;
    for (int i = 0; i < 5; i++) wr_reg(`USR_OFS_RXTX, usr_byte_t'(8'h11 * (i + 1)));
    chk_bit(thr_ready, 1'b0, "holding full");
    chk_bit(irq_thr_empty, 1'b0, "holding irq after write");
    rd_chk(`USR_OFS_LINE, 8'h00, "holding and idle low");
    @(posedge sys_clk) stall <= 1'b0;
    for (k = 0; k < 300 && !(n_taken == 4 && !tx_shift_busy); k++) @(posedge sys_clk);
    if (k == 300) begin
      error_cnt++;
      print_verdict();
    end
    repeat (3) @(posedge sys_clk);
    chk_byte(n_taken[7:0], 8'h04, "words sent");
    for (int i = 0; i < 4; i++) chk_byte(log_words[31 - 8 * i -: 8], usr_byte_t'(8'h11 * (i + 1)), "order");
    rd_chk(`USR_OFS_LINE, 8'h60, "drained");
    rd_chk(`USR_OFS_IDENT, 8'hC1, "ident value");
    rd_chk(`USR_OFS_LINE, 8'h40, "ident read clears holding");
    chk_bit(irq_thr_empty, 1'b0, "holding irq cleared");
    wr_reg(`USR_OFS_RXTX, 8'h77);
    repeat (3) @(posedge sys_clk);
    rd_chk(`USR_OFS_LINE, 8'h20, "shifter busy keeps idle low");
    $display("test transmit done");
    for (int i = 0; i < 4; i++) begin
      exp_val = (i == 2) ? 8'h00 : usr_byte_t'(1 << i);
      @(posedge sys_clk) mdm_n[i] <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 chk_bit(irq_modem, (i != 2), "modem irq on fall");
      rd_chk(`USR_OFS_MODEM, exp_val | usr_byte_t'(1 << (i + 4)), "modem fall");
      @(posedge sys_clk) mdm_n[i] <= 1'b1;
      rd_chk(`USR_OFS_MODEM, usr_byte_t'(1 << i), "modem rise");
      rd_chk(`USR_OFS_MODEM, 8'h00, "modem cleared");
    end
    $display("test modem done");
    @(posedge sys_clk) dlab_active <= 1'b1;
    rx_pulse(8'h99, 1'b0, 1'b0, 1'b0);
    rd_chk(`USR_OFS_RXTX, 8'h5E, "divisor view at offset 0");
    @(posedge sys_clk) dlab_active <= 1'b0;
    chk_bit(irq_rx_data, 1'b1, "divisor view read keeps ready");
    rd_chk(`USR_OFS_RXTX, 8'h99, "rx buffer after divisor view");
    $display("test divisor view done");
    @(posedge sys_clk) loop_enable <= 1'b1;
    // Pins are all active while the loop sources differ, so any leak of the pins shows.
    @(posedge sys_clk) mdm_n <= 4'h0;
    loop_rts <= 1'b1;
    loop_dtr <= 1'b0;
    loop_out1 <= 1'b1;
    loop_out2 <= 1'b0;
    rd_chk(`USR_OFS_MODEM, 8'h51, "loopback levels");
    $display("test loopback done");
    print_verdict();
  end
endmodule
